// ===== hdl/iwlc_status_word.sv
// interrupt status word assembly from command byte and sense bits
`timescale 1ns/1ps
module iwlc_status_word
(
  input  wire logic       sel_reset_i,
  input  wire logic       cmd_reject_i,
  input  wire logic       bus_check_i,
  input  wire logic       data_end_i,
  input  wire logic [7:0] cmd_byte_i,
  output logic [17:0]     word_o
);
  // fixed zero bits and unused error bits tied low
  always_comb
  begin
    word_o = 18'h00000;
    word_o[iwlc_pkg::SW_RESET]  = sel_reset_i;
    word_o[iwlc_pkg::SW_REJECT] = cmd_reject_i;
    word_o[iwlc_pkg::SW_BUSCHK] = bus_check_i;
    word_o[7:0] = data_end_i ? 8'h00 : cmd_byte_i;
  end
endmodule

// ===== hdl/iwlc_top.sv
// master side control of the intercomputer word link
`timescale 1ns/1ps
module iwlc_top
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // master function word strobe
  input  wire logic        fw_valid_i,
  input  wire logic [17:0] master_function_word_i,
  // slave command channel; parity bit makes byte odd when good
  input  wire logic        slv_cmd_valid_i,
  input  wire logic [7:0]  slv_cmd_i,
  input  wire logic        slv_cmd_par_i,
  input  wire logic        slv_sel_reset_i,
  // data word end of transfer from the data path
  input  wire logic        xfer_done_i,
  // decoded function word to the slave (top bits dropped)
  output logic [15:0]      slv_fw_o,
  output logic [11:0]      count_o,
  output logic [1:0]       format_o,
  output logic [1:0]       op_o,
  output logic             attention_o,
  output logic             fw_reject_o,
  // interrupt to master with status word
  output logic             int_o,
  output logic [17:0]      interrupt_status_word_o,
  output logic [6:0]       error_status_o,
  output logic             linked_o,
  output logic             busy_o,
  output logic [2:0]       state_o
);
  iwlc_pkg::iwlc_state_e state_r, state_nxt;
  logic [15:0] slv_fw_r, slv_fw_nxt;
  logic [1:0]  op_r, op_nxt;
  logic        attn_r, attn_nxt;
  logic        rej_r, rej_nxt;
  logic        int_r, int_nxt;
  logic [17:0] isw_r, isw_nxt;
  logic        srst_r, srst_nxt;
  logic        crej_r, crej_nxt;
  logic        bchk_r, bchk_nxt;
  logic        fw_ok, cmd_known, par_bad, is_ext, data_end;
  logic        srst_pend, crej_pend, bchk_pend;
  logic [17:0] word_w;

  // function word and command byte field checks
  always_comb
  begin
    fw_ok = (master_function_word_i[3:2] != iwlc_pkg::FMT_BAD) &&
            (master_function_word_i[1:0] != iwlc_pkg::CTL_BAD);
    is_ext = slv_cmd_i[1:0] == iwlc_pkg::CCODE_EXT;
    cmd_known = is_ext ||
                slv_cmd_i[1:0] == iwlc_pkg::CMD_IN ||
                slv_cmd_i[1:0] == iwlc_pkg::CMD_OUT ||
                slv_cmd_i[3:0] == iwlc_pkg::CMD_SENSE ||
                slv_cmd_i[5:0] == 6'h00 ||
                slv_cmd_i[5:0] == 6'h10 ||
                slv_cmd_i[5:0] == 6'h20;
    // even parity over byte and parity bit means a bus fault
    par_bad = ~^{slv_cmd_i, slv_cmd_par_i};
    data_end = xfer_done_i;
    // pending sense with this cycle's events; the status word shows these
    srst_pend = srst_r | slv_sel_reset_i;
    crej_pend = crej_r | (slv_cmd_valid_i & ~cmd_known);
    bchk_pend = bchk_r | (slv_cmd_valid_i & par_bad);
  end

  iwlc_status_word u_sw
  (
    .sel_reset_i  (srst_pend),
    .cmd_reject_i (crej_pend),
    .bus_check_i  (bchk_pend),
    .data_end_i   (data_end),
    .cmd_byte_i   (slv_cmd_i),
    .word_o       (word_w)
  );

  // sense bits are sticky until reported; a set in the interrupt cycle is
  // captured into that word, so nothing is lost when the clear comes
  always_comb
  begin
    srst_nxt = srst_pend;
    crej_nxt = crej_pend;
    bchk_nxt = bchk_pend;
    if (int_nxt)
    begin
      srst_nxt = slv_sel_reset_i;
      crej_nxt = 1'b0;
      bchk_nxt = 1'b0;
    end
  end

  // link sequence and function word decode
  always_comb
  begin
    state_nxt  = state_r;
    slv_fw_nxt = slv_fw_r;
    op_nxt     = op_r;
    attn_nxt   = 1'b0;
    rej_nxt    = 1'b0;
    int_nxt    = 1'b0;
    isw_nxt    = isw_r;
    if (fw_valid_i)
    begin
      if (!fw_ok)
        rej_nxt = 1'b1;
      else
      begin
        slv_fw_nxt = master_function_word_i[15:0];
        op_nxt = master_function_word_i[1:0];
        if (master_function_word_i[1:0] == iwlc_pkg::CTL_ATTN)
        begin
          attn_nxt = 1'b1;
          if (state_r == iwlc_pkg::IWLC_IDLE)
            state_nxt = iwlc_pkg::IWLC_HS;
        end
        else
        begin
          case (state_r)
            iwlc_pkg::IWLC_READY:
              state_nxt = iwlc_pkg::IWLC_XFER;
            iwlc_pkg::IWLC_CHEND:
              if (master_function_word_i[1:0] == iwlc_pkg::CTL_IN)
                state_nxt = iwlc_pkg::IWLC_INPUT;
            default:
              state_nxt = state_r;
          endcase
        end
      end
    end
    // channel end when the data block finishes
    if (data_end && state_r == iwlc_pkg::IWLC_XFER)
    begin
      int_nxt = 1'b1;
      isw_nxt = word_w;
      state_nxt = iwlc_pkg::IWLC_CHEND;
    end
    else if (slv_cmd_valid_i && is_ext)
    begin
      int_nxt = 1'b1;
      isw_nxt = word_w;
      case (state_r)
        iwlc_pkg::IWLC_HS:
          if (slv_cmd_i[3:2] == iwlc_pkg::ICODE_OUTEND)
            state_nxt = iwlc_pkg::IWLC_READY;
        iwlc_pkg::IWLC_CHEND,
        iwlc_pkg::IWLC_INPUT,
        iwlc_pkg::IWLC_XFER:
          state_nxt = iwlc_pkg::IWLC_READY;
        default:
          state_nxt = state_r;
      endcase
    end
  end

  // registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r  <= iwlc_pkg::IWLC_IDLE;
      slv_fw_r <= 16'h0000;
      op_r     <= 2'h0;
      attn_r   <= 1'b0;
      rej_r    <= 1'b0;
      int_r    <= 1'b0;
      isw_r    <= 18'h00000;
      srst_r   <= 1'b0;
      crej_r   <= 1'b0;
      bchk_r   <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      slv_fw_r <= slv_fw_nxt;
      op_r     <= op_nxt;
      attn_r   <= attn_nxt;
      rej_r    <= rej_nxt;
      int_r    <= int_nxt;
      isw_r    <= isw_nxt;
      srst_r   <= srst_nxt;
      crej_r   <= crej_nxt;
      bchk_r   <= bchk_nxt;
    end
  end

  // outputs; error field shared with the slave side sense byte
  assign slv_fw_o    = slv_fw_r;
  assign count_o     = slv_fw_r[iwlc_pkg::CNT_MSB:iwlc_pkg::CNT_LSB];
  assign format_o    = slv_fw_r[iwlc_pkg::FMT_LSB+1:
                                iwlc_pkg::FMT_LSB];
  assign op_o        = op_r;
  assign attention_o = attn_r;
  assign fw_reject_o = rej_r;
  assign int_o       = int_r;
  assign interrupt_status_word_o = isw_r;
  assign error_status_o = {crej_r, 1'b0, bchk_r, 4'h0};
  assign linked_o    = state_r != iwlc_pkg::IWLC_IDLE &&
                       state_r != iwlc_pkg::IWLC_HS;
  assign busy_o      = state_r == iwlc_pkg::IWLC_XFER ||
                       state_r == iwlc_pkg::IWLC_CHEND ||
                       state_r == iwlc_pkg::IWLC_INPUT;
  assign state_o     = state_r;

  // checks
  property p_zero_bits;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    int_o |-> interrupt_status_word_o[17] == 1'b0 &&
              interrupt_status_word_o[8] == 1'b0;
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("status word fixed bits not zero");

  property p_bad_fw;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    fw_valid_i && !fw_ok && !int_nxt |=> fw_reject_o && $stable(state_r);
  endproperty
  a_bad_fw: assert property (p_bad_fw)
    else $error("bad function word changed state");

  property p_drop_top;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    fw_valid_i && fw_ok |=> slv_fw_o == $past(master_function_word_i[15:0]);
  endproperty
  a_drop_top: assert property (p_drop_top)
    else $error("forwarded function word wrong");

  sequence s_chend;
    state_r == iwlc_pkg::IWLC_XFER && xfer_done_i;
  endsequence
  property p_chend;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_chend |=> int_o && interrupt_status_word_o[7:0] == 8'h00;
  endproperty
  a_chend: assert property (p_chend)
    else $error("channel end status word wrong");

  property p_handshake;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    state_r == iwlc_pkg::IWLC_HS && slv_cmd_valid_i &&
    slv_cmd_i[3:0] == 4'h7 |=> linked_o && int_o;
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("handshake did not complete");

  property p_busck;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    slv_cmd_valid_i && par_bad && !int_nxt |=> error_status_o[4];
  endproperty
  a_busck: assert property (p_busck)
    else $error("bus out check missed");

  property p_reject;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    slv_cmd_valid_i && !cmd_known && !int_nxt |=> error_status_o[6];
  endproperty
  a_reject: assert property (p_reject)
    else $error("command reject missed");

  property p_input;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    state_r == iwlc_pkg::IWLC_CHEND && fw_valid_i && fw_ok &&
    master_function_word_i[1:0] == iwlc_pkg::CTL_IN && !slv_cmd_valid_i
    |=> state_r == iwlc_pkg::IWLC_INPUT;
  endproperty
  a_input: assert property (p_input)
    else $error("input phase not entered");
endmodule

// ===== pkg/iwlc_pkg.sv
// package of constants and types for the intercomputer word link control
package iwlc_pkg;
  localparam int FW_W       = 18;
  localparam int CNT_LSB    = 4;
  localparam int CNT_MSB    = 15;
  localparam int FMT_LSB    = 2;
  localparam int CTL_LSB    = 0;
  localparam int SW_RESET   = 16;
  localparam int SW_REJECT  = 15;
  localparam int SW_BUSCHK  = 13;
  localparam logic [1:0] FMT_BAD     = 2'h3;
  localparam logic [1:0] CTL_ATTN    = 2'h0;
  localparam logic [1:0] CTL_IN      = 2'h1;
  localparam logic [1:0] CTL_OUT     = 2'h2;
  localparam logic [1:0] CTL_BAD     = 2'h3;
  localparam logic [1:0] ICODE_OUTEND = 2'h1;
  localparam logic [1:0] CCODE_EXT   = 2'h3;
  localparam logic [7:0] CMD_SET_INT_MASK = 8'h03;
  localparam logic [7:0] CMD_TEST_IO  = 8'h00;
  localparam logic [7:0] CMD_SET_INH  = 8'h10;
  localparam logic [7:0] CMD_CLR_INH  = 8'h20;
  localparam logic [3:0] CMD_SENSE    = 4'h4;
  localparam logic [1:0] CMD_IN       = 2'h2;
  localparam logic [1:0] CMD_OUT      = 2'h1;

  // link sequence states, gray coded along the usual path
  typedef enum logic [2:0]
  {
    IWLC_IDLE  = 3'h0,
    IWLC_HS    = 3'h1,
    IWLC_READY = 3'h3,
    IWLC_XFER  = 3'h2,
    IWLC_CHEND = 3'h6,
    IWLC_INPUT = 3'h7
  } iwlc_state_e;
endpackage

// ===== tb/iwlc_slave_model.sv
// slave channel model that offers command bytes with odd parity
`timescale 1ns/1ps
module iwlc_slave_model
(
  input  wire logic       ref_clk_i,
  input  wire logic       req_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       bad_par_i,
  output logic            valid_o,
  output logic [7:0]      cmd_o,
  output logic            par_o
);
  logic [8:0] last_r = 9'h000;
  // remember the last byte so an idle bus never repeats it
  always_ff @(posedge ref_clk_i)
  begin
    if (req_i)
    begin
      last_r <= {par_o, cmd_o};
    end
  end
  // bad_par_i spoils the parity on purpose to provoke a bus check
  assign valid_o = req_i;
  assign cmd_o   = req_i ? byte_i : ~last_r[7:0];
  assign par_o   = req_i ? (~^byte_i) ^ bad_par_i : ~last_r[8];
endmodule

// ===== tb/iwlc_top_bench.sv
// self-checking bench for the word link control
`timescale 1ns/1ps
module iwlc_top_bench;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        fw_valid_i = 1'b0;
  logic [17:0] master_function_word_i = 18'h00000;
  logic        req = 1'b0;
  logic        bad = 1'b0;
  logic [7:0]  cb = 8'h00;
  logic        slv_sel_reset_i = 1'b0;
  logic        xfer_done_i = 1'b0;
  logic        slv_cmd_valid_i;
  logic [7:0]  slv_cmd_i;
  logic        slv_cmd_par_i;
  logic [15:0] slv_fw_o;
  logic [11:0] count_o;
  logic [1:0]  format_o;
  logic [1:0]  op_o;
  logic        attention_o;
  logic        fw_reject_o;
  logic        int_o;
  logic [17:0] interrupt_status_word_o;
  logic [6:0]  error_status_o;
  logic        linked_o;
  logic        busy_o;
  logic [2:0]  state_o;
  logic        f_r = 1'b0;
  logic        f_rej = 1'b0;
  logic        f_bus = 1'b0;
  logic [31:0] x = 32'h0000001d;
  logic [31:0] r;
  logic [17:0] w;
  int          num_errors = 0;
  int          n_compared = 0;

  iwlc_top dut (.ref_clk_i, .rst_n_i, .fw_valid_i, .master_function_word_i,
    .slv_cmd_valid_i, .slv_cmd_i, .slv_cmd_par_i, .slv_sel_reset_i,
    .xfer_done_i, .slv_fw_o, .count_o, .format_o, .op_o, .attention_o,
    .fw_reject_o, .int_o, .interrupt_status_word_o, .error_status_o,
    .linked_o, .busy_o, .state_o);

  iwlc_slave_model slv (.ref_clk_i, .req_i(req), .byte_i(cb),
    .bad_par_i(bad), .valid_o(slv_cmd_valid_i), .cmd_o(slv_cmd_i),
    .par_o(slv_cmd_par_i));

  // free running 25 MHz clock
  initial
  begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // expected status word from the pending sense bits and a command byte
  function automatic logic [17:0] exp_sw(logic [7:0] c);
    return {1'b0, f_r, f_rej, 1'b0, f_bus, 4'h0, 1'b0, c};
  endfunction

  // command bytes the unit recognises; anything else is rejected
  function automatic logic known(logic [7:0] b);
    return (b[1:0] != 2'h0) || (b[3:0] == 4'h4) || (b[5:0] == 6'h00) ||
      (b[5:0] == 6'h10) || (b[5:0] == 6'h20);
  endfunction

  task automatic close_out();
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(string nm, logic [17:0] got, logic [17:0] ex);
    n_compared++;
    if (got !== ex)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chk_st(logic [2:0] s);
    logic ln;
    logic bz;
    ln = s != iwlc_pkg::IWLC_IDLE && s != iwlc_pkg::IWLC_HS;
    bz = s == iwlc_pkg::IWLC_XFER || s == iwlc_pkg::IWLC_CHEND ||
      s == iwlc_pkg::IWLC_INPUT;
    chk("state", {15'h0, state_o}, {15'h0, s});
    chk("link", {17'h0, linked_o}, {17'h0, ln});
    chk("busy", {17'h0, busy_o}, {17'h0, bz});
  endtask

  // an issued interrupt swallows the pending sense bits
  task automatic chk_int(logic on, logic [7:0] c);
    chk("int", {17'h0, int_o}, {17'h0, on});
    if (on)
    begin
      chk("isw", interrupt_status_word_o, exp_sw(c));
      f_r = 1'b0;
      f_rej = 1'b0;
      f_bus = 1'b0;
    end
  endtask

  // all drives start and end at a falling edge
  task automatic fw(logic [17:0] v, logic [2:0] s);
    logic rej;
    rej = (v[3:2] == 2'h3) || (v[1:0] == 2'h3);
    master_function_word_i = v;
    fw_valid_i = 1'b1;
    @(negedge ref_clk_i);
    fw_valid_i = 1'b0;
    chk("rej", {17'h0, fw_reject_o}, {17'h0, rej});
    chk("attn", {17'h0, attention_o}, {17'h0, !rej && v[1:0] == 2'h0});
    chk_st(s);
    if (!rej)
    begin
      chk("fw", {2'h0, slv_fw_o}, {2'h0, v[15:0]});
      chk("cnt", {6'h0, count_o}, {6'h0, v[15:4]});
      chk("fmt", {14'h0, format_o, op_o}, {14'h0, v[3:0]});
    end
    // idle cycle so a following call never re-raises the strobe at once
    @(negedge ref_clk_i);
  endtask

  task automatic sc(logic [7:0] b, logic bd, logic [2:0] s);
    cb = b;
    bad = bd;
    req = 1'b1;
    @(negedge ref_clk_i);
    req = 1'b0;
    f_bus = f_bus | bd;
    f_rej = f_rej | !known(b);
    chk_int(b[1:0] == 2'h3, b);
    chk("err", {11'h0, error_status_o}, {11'h0, f_rej, 1'b0, f_bus, 4'h0});
    chk_st(s);
    // idle cycle so back to back commands keep a strobe gap
    @(negedge ref_clk_i);
  endtask

  task automatic dn(logic [2:0] s);
    xfer_done_i = 1'b1;
    @(negedge ref_clk_i);
    xfer_done_i = 1'b0;
    chk_int(1'b1, 8'h00);
    chk_st(s);
  endtask

  // main sequence: refusal, handshake, then random transfers
  initial
  begin
    repeat (20) @(negedge ref_clk_i);
    chk_st(iwlc_pkg::IWLC_IDLE);
    chk_int(1'b0, 8'h00);
    rst_n_i = 1'b1;
    fw(18'h0000c, iwlc_pkg::IWLC_IDLE);
    fw(18'h30004, iwlc_pkg::IWLC_HS);
    sc(8'h07, 1'b0, iwlc_pkg::IWLC_READY);
    chk("link", {17'h0, linked_o}, 18'h00001);
    fw(18'h00063, iwlc_pkg::IWLC_READY);
    for (int i = 0; i < 40; i++)
    begin
      r = rnd();
      w[11:0] = (i == 0) ? 12'h006 : (i == 1) ? 12'hfff : 12'(6 + r % 4090);
      w = {r[31:30], w[11:0], 2'(r[29:28] % 3), 2'(1 + r[27])};
      // a few special functions: device code in place of the byte count
      if (i > 1 && i < 5)
        w = {2'h0, 12'(i), 2'h1, 2'h2};
      fw(w, iwlc_pkg::IWLC_XFER);
      if (r[0])
        sc(8'h00, 1'b1, iwlc_pkg::IWLC_XFER);
      if (r[1])
        sc(8'h08, 1'b0, iwlc_pkg::IWLC_XFER);
      if (r[2])
      begin
        slv_sel_reset_i = 1'b1;
        @(negedge ref_clk_i);
        slv_sel_reset_i = 1'b0;
        f_r = 1'b1;
      end
      dn(iwlc_pkg::IWLC_CHEND);
      if (w[1:0] == iwlc_pkg::CTL_IN)
        fw(w, iwlc_pkg::IWLC_INPUT);
      sc({4'(r[7:4] % 6), r[8] ? 2'h1 : 2'h2, 2'h3}, 1'b0,
        iwlc_pkg::IWLC_READY);
    end
    close_out();
  end

  // hang guard, far beyond the expected few hundred cycles
  initial
  begin
    #400000;
    num_errors++;
    close_out();
  end
endmodule
